// ==== rtl/ptpc_pkg.sv ====
// constants and types for the proximity threshold and persistence block
// Behaviour
// - prox irq when outside thresholds and persistence met
// - prox thresholds 16-bit at 0x08..0x0b, low first
// - independent persistence per proximity and light
// - light irq compares channel zero result only
// - prox persistence zero: interrupt every cycle
// - prox codes 1..15 need that many out-of-range
// - light persistence zero: interrupt every cycle
// - light codes 1..3 need 1..3 results
// - light codes 4..15 need 5..60 step five
// - gain level bit scales two lowest gains
// - wait extension bit multiplies wait by 12
// - drive reduce bit cuts emitter current ninefold
// - emit exactly programmed pulse count per accumulation
// - emitter pulses at 62.5 kHz
// - irq output gated by mask bits 5 and 4
// - status bits 5 and 4 report pending irqs
// - irq held until self-clearing clear command
// - base wait is two's complement times 2.73 ms
package ptpc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_WAIT = 8'h03;
  localparam logic [7:0] ADDR_ALT_LO = 8'h04;
  localparam logic [7:0] ADDR_ALT_HI = 8'h05;
  localparam logic [7:0] ADDR_AHT_LO = 8'h06;
  localparam logic [7:0] ADDR_AHT_HI = 8'h07;
  localparam logic [7:0] ADDR_PLT_LO = 8'h08;
  localparam logic [7:0] ADDR_PLT_HI = 8'h09;
  localparam logic [7:0] ADDR_PHT_LO = 8'h0a;
  localparam logic [7:0] ADDR_PHT_HI = 8'h0b;
  localparam logic [7:0] ADDR_PERS = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG = 8'h0d;
  localparam logic [7:0] ADDR_PULSE = 8'h0e;
  localparam logic [7:0] ADDR_STATUS = 8'h13;
  // field positions
  localparam int EN_PROX_MASK = 5;
  localparam int EN_LIGHT_MASK = 4;
  localparam int EN_WAIT = 3;
  localparam int ST_PROX_IRQ = 5;
  localparam int ST_LIGHT_IRQ = 4;
  localparam int CFG_GAIN_LEVEL = 2;
  localparam int CFG_WAIT_EXT = 1;
  localparam int CFG_DRIVE_RED = 0;
  localparam logic [7:0] CFG_WMASK = 8'h07;
  // clear command codes (low five bits of command byte)
  localparam logic [4:0] CMD_CLR_PROX = 5'h05;
  localparam logic [4:0] CMD_CLR_LIGHT = 5'h06;
  localparam logic [4:0] CMD_CLR_BOTH = 5'h07;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_WAIT = 8'hff;
  localparam logic [7:0] RST_PULSE = 8'h00;
  // timing: clock 250 MHz
  localparam int CLK_HZ = 250000000;
  localparam int PULSE_HZ = 62500;
  localparam int PULSE_PERIOD = CLK_HZ / PULSE_HZ;
  localparam int PULSE_HIGH = PULSE_PERIOD / 2;
  localparam int WAIT_UNIT_US = 2730;
  localparam int WAIT_UNIT_CYC = WAIT_UNIT_US * (CLK_HZ / 1000000);
  localparam logic [3:0] WAIT_EXT_FACTOR = 4'hc;
  localparam logic [3:0] WAIT_NORM_FACTOR = 4'h1;
  localparam logic [2:0] GAIN_SCALED_MAX = 3'h1;
  localparam logic [5:0] LIGHT_STEP = 6'h05;
  localparam logic [3:0] LIGHT_LINEAR_MAX = 4'h3;
  // pulse engine states
  typedef enum logic [1:0] {
    PTPC_P_IDLE = 2'b00,
    PTPC_P_HIGH = 2'b01,
    PTPC_P_LOW = 2'b10
  } ptpc_pstate_t;
endpackage : ptpc_pkg

// ==== rtl/ptpc_cfg_if.sv ====
// carrier between top and emitter pulse engine
`timescale 1ns/1ps
interface ptpc_cfg_if;
  logic start; // accumulation begins
  logic [7:0] count; // pulses wanted
  logic busy; // burst running
  logic pulse; // emitter level
  modport ctrl (output start, output count, input busy, input pulse);
  modport eng (input start, input count, output busy, output pulse);
endinterface : ptpc_cfg_if

// ==== rtl/ptpc_emitter.sv ====
// emitter pulse engine at 62.5 kHz
`timescale 1ns/1ps
module ptpc_emitter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  ptpc_cfg_if.eng cfg
);
  typedef struct packed {
    ptpc_pkg::ptpc_pstate_t st;
    logic [7:0] left;
    logic [15:0] tick;
    logic pulse;
  } ptpc_emit_t;
  ptpc_emit_t s_q, s_d;
  localparam logic [15:0] PER_M1 = 16'(ptpc_pkg::PULSE_PERIOD - 1);
  localparam logic [15:0] HI_M1 = 16'(ptpc_pkg::PULSE_HIGH - 1);
  assign cfg.busy = (s_q.st != ptpc_pkg::PTPC_P_IDLE);
  assign cfg.pulse = s_q.pulse;
  // next state of pulse burst
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      ptpc_pkg::PTPC_P_IDLE:
      begin
        s_d.pulse = 1'b0;
        if (cfg.start && cfg.count != 8'h00)
        begin
          s_d.st = ptpc_pkg::PTPC_P_HIGH;
          s_d.left = cfg.count;
          s_d.tick = 16'h0000;
          s_d.pulse = 1'b1;
        end
      end
      ptpc_pkg::PTPC_P_HIGH:
      begin
        s_d.tick = s_q.tick + 16'h0001;
        if (s_q.tick == HI_M1)
        begin
          s_d.st = ptpc_pkg::PTPC_P_LOW;
          s_d.pulse = 1'b0;
          s_d.left = s_q.left - 8'h01;
        end
      end
      ptpc_pkg::PTPC_P_LOW:
      begin
        s_d.tick = s_q.tick + 16'h0001;
        if (s_q.tick == PER_M1)
        begin
          s_d.tick = 16'h0000;
          if (s_q.left == 8'h00)
            s_d.st = ptpc_pkg::PTPC_P_IDLE;
          else
          begin
            s_d.st = ptpc_pkg::PTPC_P_HIGH;
            s_d.pulse = 1'b1;
          end
        end
      end
      default: s_d.st = ptpc_pkg::PTPC_P_IDLE;
    endcase
  end
  // register with sync reset and enable
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else if (ce_i)
      s_q <= s_d;
  end
endmodule : ptpc_emitter

// ==== rtl/ptpc_top.sv ====
// register file, threshold compare, persistence filters, wait timer
`timescale 1ns/1ps
module ptpc_top (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic WR_I, // write strobe from serial interface
  input wire logic RD_I, // read strobe
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic CMD_CLR_I, // special function strobe
  input wire logic [4:0] CMD_CODE_I,
  input wire logic PROX_DONE_I, // proximity cycle complete
  input wire logic [15:0] PROX_RESULT_I,
  input wire logic LIGHT_DONE_I, // light cycle complete
  input wire logic [15:0] CH0_RESULT_I,
  input wire logic WAIT_START_I, // begin wait period
  input wire logic ACCUM_START_I, // enter prox accumulation
  output logic [7:0] RDATA_O,
  output logic IRQ_N_O,
  output logic EMITTER_DRIVE_PIN_O,
  output logic DRIVE_REDUCE_O,
  output logic [2:0] GAIN_MULT_SEL_O,
  output logic WAIT_BUSY_O
);
  // whole state in one record
  // the record holds registers, counters and
  //   the registered outputs together, so one
  //   clock enable freezes all of them at once
  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] wait_period;
    logic [15:0] light_lo;
    logic [15:0] light_hi;
    logic [15:0] prox_lo;
    logic [15:0] prox_hi;
    logic [7:0] persist;
    logic [7:0] config_r;
    logic [7:0] pulse_count;
    logic prox_flag;
    logic light_flag;
    logic [3:0] prox_cnt;
    logic [5:0] light_cnt;
    logic [31:0] wait_cnt;
    logic [3:0] wait_mul;
    logic [7:0] wait_units;
    logic wait_busy;
    logic [7:0] rdata;
    logic irq_n;
    logic drive_pin;
    logic drive_red;
    logic [2:0] gain_sel;
  } ptpc_state_t;
  ptpc_state_t s_q, s_d;
  ptpc_cfg_if cfg_bus ();
  // block overview:
  //   register file, one byte per strobe
  //   two window compares, one per channel
  //   two persistence counters, never shared
  //   two sticky flags, cleared by command only
  //   wait timer counting whole units
  //   emitter burst handed to a child engine
  // every path runs on one clock, so no
  //   synchroniser sits on any input; a strobe
  //   from another domain must be brought
  //   across before it reaches this block
  // cost: one more flop stage of latency is
  //   saved, at the price of that duty upstream
  // light persistence code to count
  // codes above the linear part step by five
  function automatic logic [5:0] light_need(input logic [3:0] code);
    logic [5:0] r;
    r = 6'h00;
    if (code <= ptpc_pkg::LIGHT_LINEAR_MAX)
      r = {2'b00, code};
    else
      r = 6'((code - ptpc_pkg::LIGHT_LINEAR_MAX) * ptpc_pkg::LIGHT_STEP);
    return r;
  endfunction
  // outside window test
  // strict compare: a result equal to either
  //   threshold counts as inside the window
  // a low threshold above the high one makes
  //   every result outside; software avoids it
  function automatic logic outside(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (v < lo) || (v > hi);
  endfunction
  // wait step length in base units
  function automatic logic [3:0] wait_factor(input logic [7:0] cfg);
    return cfg[ptpc_pkg::CFG_WAIT_EXT] ? ptpc_pkg::WAIT_EXT_FACTOR :
      ptpc_pkg::WAIT_NORM_FACTOR;
  endfunction
  // persistence codes split: upper nibble for
  //   proximity, lower nibble for light
  // result capture; same clock domain so no synchroniser
  logic prox_out, light_out, prox_hit, light_hit;
  logic clr_prox, clr_light;
  logic [3:0] prox_code;
  logic [5:0] light_req;
  assign prox_code = s_q.persist[7:4];
  assign light_req = light_need(s_q.persist[3:0]);
  assign prox_out = outside(PROX_RESULT_I, s_q.prox_lo, s_q.prox_hi);
  assign light_out = outside(CH0_RESULT_I, s_q.light_lo, s_q.light_hi);
  // clear codes decode only with the strobe
  //   high; other codes do nothing here
  assign clr_prox = CMD_CLR_I &&
    (CMD_CODE_I == ptpc_pkg::CMD_CLR_PROX || CMD_CODE_I == ptpc_pkg::CMD_CLR_BOTH);
  assign clr_light = CMD_CLR_I &&
    (CMD_CODE_I == ptpc_pkg::CMD_CLR_LIGHT || CMD_CODE_I == ptpc_pkg::CMD_CLR_BOTH);
  // hit decisions, each channel on its own counter
  // hit rules in short:
  //   code zero: every completed cycle hits
  //   code n: n-th consecutive outside result hits; light codes 4..15 need 5..60
  // the counter holds results already seen, so
  //   the current one is added before comparing
  // counter never wraps: it restarts on a hit
  //   before it can pass the largest code
  // an inside result never hits unless code zero
  always_comb
  begin
    prox_hit = 1'b0;
    light_hit = 1'b0;
    if (PROX_DONE_I)
    begin
      if (prox_code == 4'h0)
        prox_hit = 1'b1;
      else if (prox_out && (s_q.prox_cnt + 4'h1) >= prox_code)
        prox_hit = 1'b1;
    end
    if (LIGHT_DONE_I)
    begin
      if (s_q.persist[3:0] == 4'h0)
        light_hit = 1'b1;
      else if (light_out && (s_q.light_cnt + 6'h01) >= light_req)
        light_hit = 1'b1;
    end
  end
  // emitter engine link
  // the engine ignores a start during a burst;
  //   gating here too keeps the request clean
  //   for anything later added on this link
  assign cfg_bus.start = ACCUM_START_I && !cfg_bus.busy;
  assign cfg_bus.count = s_q.pulse_count;
  ptpc_emitter u_emit (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .cfg(cfg_bus.eng)
  );
  // next state
  always_comb
  begin
    s_d = s_q;
    // register writes
    // thresholds are stored byte by byte, so a
    //   host changing both halves leaves a short
    //   window where the compare sees a mixed value
    // accepted to keep every write single byte
    // reserved configuration bits dropped on entry
    if (WR_I)
    begin
      if (ADDR_I == ptpc_pkg::ADDR_ENABLE)
        s_d.enable = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_WAIT)
        s_d.wait_period = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_ALT_LO)
        s_d.light_lo[7:0] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_ALT_HI)
        s_d.light_lo[15:8] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_AHT_LO)
        s_d.light_hi[7:0] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_AHT_HI)
        s_d.light_hi[15:8] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_PLT_LO)
        s_d.prox_lo[7:0] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_PLT_HI)
        s_d.prox_lo[15:8] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_PHT_LO)
        s_d.prox_hi[7:0] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_PHT_HI)
        s_d.prox_hi[15:8] = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_PERS)
        s_d.persist = WDATA_I;
      else if (ADDR_I == ptpc_pkg::ADDR_CONFIG)
        s_d.config_r = WDATA_I & ptpc_pkg::CFG_WMASK;
      else if (ADDR_I == ptpc_pkg::ADDR_PULSE)
        s_d.pulse_count = WDATA_I;
    end
    // reads; unmapped addresses return zero
    // read data is registered, so a read answers
    //   one cycle after its strobe and then stands
    //   until the next read
    // status bits come from the flags, not the pin
    if (RD_I)
    begin
      if (ADDR_I == ptpc_pkg::ADDR_ENABLE)
        s_d.rdata = s_q.enable;
      else if (ADDR_I == ptpc_pkg::ADDR_WAIT)
        s_d.rdata = s_q.wait_period;
      else if (ADDR_I == ptpc_pkg::ADDR_ALT_LO)
        s_d.rdata = s_q.light_lo[7:0];
      else if (ADDR_I == ptpc_pkg::ADDR_ALT_HI)
        s_d.rdata = s_q.light_lo[15:8];
      else if (ADDR_I == ptpc_pkg::ADDR_AHT_LO)
        s_d.rdata = s_q.light_hi[7:0];
      else if (ADDR_I == ptpc_pkg::ADDR_AHT_HI)
        s_d.rdata = s_q.light_hi[15:8];
      else if (ADDR_I == ptpc_pkg::ADDR_PLT_LO)
        s_d.rdata = s_q.prox_lo[7:0];
      else if (ADDR_I == ptpc_pkg::ADDR_PLT_HI)
        s_d.rdata = s_q.prox_lo[15:8];
      else if (ADDR_I == ptpc_pkg::ADDR_PHT_LO)
        s_d.rdata = s_q.prox_hi[7:0];
      else if (ADDR_I == ptpc_pkg::ADDR_PHT_HI)
        s_d.rdata = s_q.prox_hi[15:8];
      else if (ADDR_I == ptpc_pkg::ADDR_PERS)
        s_d.rdata = s_q.persist;
      else if (ADDR_I == ptpc_pkg::ADDR_CONFIG)
        s_d.rdata = s_q.config_r;
      else if (ADDR_I == ptpc_pkg::ADDR_PULSE)
        s_d.rdata = s_q.pulse_count;
      else if (ADDR_I == ptpc_pkg::ADDR_STATUS)
      begin
        s_d.rdata = ptpc_pkg::RST_ZERO;
        s_d.rdata[ptpc_pkg::ST_PROX_IRQ] = s_q.prox_flag;
        s_d.rdata[ptpc_pkg::ST_LIGHT_IRQ] = s_q.light_flag;
      end
      else
        s_d.rdata = ptpc_pkg::RST_ZERO;
    end
    // counters: an inside result restarts the run,
    //   a hit restarts it too, and a clear command
    //   wins over a count in the same cycle
    // proximity persistence counter
    if (PROX_DONE_I)
    begin
      if (!prox_out || prox_hit)
        s_d.prox_cnt = 4'h0;
      else
        s_d.prox_cnt = s_q.prox_cnt + 4'h1;
    end
    if (clr_prox)
      s_d.prox_cnt = 4'h0;
    // light persistence counter
    if (LIGHT_DONE_I)
    begin
      if (!light_out || light_hit)
        s_d.light_cnt = 6'h00;
      else
        s_d.light_cnt = s_q.light_cnt + 6'h01;
    end
    if (clr_light)
      s_d.light_cnt = 6'h00;
    // flags: clear then set, so a same-cycle event wins
    // a hit in the very cycle of a clear must
    //   not be lost, hence the set comes last
    if (clr_prox)
      s_d.prox_flag = 1'b0;
    if (prox_hit)
      s_d.prox_flag = 1'b1;
    if (clr_light)
      s_d.light_flag = 1'b0;
    if (light_hit)
      s_d.light_flag = 1'b1;
    // masked irq pin, active low
    // pin follows the next flag values, so a hit
    //   shows one cycle after the result, the
    //   same latency as the status register
    // mask changes act two cycles after the write
    s_d.irq_n = !((s_d.prox_flag && s_q.enable[ptpc_pkg::EN_PROX_MASK]) ||
                  (s_d.light_flag && s_q.enable[ptpc_pkg::EN_LIGHT_MASK]));
    // wait timer: units = 256 - value, each unit 2.73 ms, times 12 if extended
    // layout:
    //   wait_cnt cycles inside one base unit
    //   wait_mul base units left in this step
    //   wait_units steps left after this one
    // trade-off: a private unit counter rather
    //   than a prescaler shared with timers that
    //   this block does not own
    // a start while busy is ignored, not queued
    // units reload from the register at start only
    if (WAIT_START_I && s_q.enable[ptpc_pkg::EN_WAIT] && !s_q.wait_busy)
    begin
      s_d.wait_busy = 1'b1;
      s_d.wait_units = ~s_q.wait_period;
      s_d.wait_mul = wait_factor(s_q.config_r);
      s_d.wait_cnt = 32'h00000000;
    end
    else if (s_q.wait_busy)
    begin
      s_d.wait_cnt = s_q.wait_cnt + 32'h00000001;
      if (s_q.wait_cnt == 32'(ptpc_pkg::WAIT_UNIT_CYC - 1))
      begin
        s_d.wait_cnt = 32'h00000000;
        if (s_q.wait_mul > 4'h1)
          s_d.wait_mul = s_q.wait_mul - 4'h1;
        else if (s_q.wait_units == 8'h00)
          s_d.wait_busy = 1'b0;
        else
        begin
          s_d.wait_units = s_q.wait_units - 8'h01;
          s_d.wait_mul = wait_factor(s_q.config_r);
        end
      end
    end
    // analog control outputs
    // registered copies of configuration bits and of the emitter level;
    //   the gain select only says scaled or not,
    //   the gain itself is chosen elsewhere
    // software keeps the scale off above 8x gain
    s_d.drive_red = s_q.config_r[ptpc_pkg::CFG_DRIVE_RED];
    s_d.gain_sel = s_q.config_r[ptpc_pkg::CFG_GAIN_LEVEL] ?
      ptpc_pkg::GAIN_SCALED_MAX : 3'h0;
    s_d.drive_pin = cfg_bus.pulse;
  end
  // reset loads every field, including the ones
  //   whose reset value is not zero; reset is
  //   taken even while the clock enable is low
  // state register; clock enable freezes everything
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      s_q <= '0;
      s_q.wait_period <= ptpc_pkg::RST_WAIT;
      s_q.pulse_count <= ptpc_pkg::RST_PULSE;
      s_q.irq_n <= 1'b1;
    end
    else if (CE_I)
      s_q <= s_d;
  end
  // outputs come straight from the state record,
  //   never from the next-state copy
  assign RDATA_O = s_q.rdata;
  assign IRQ_N_O = s_q.irq_n;
  assign EMITTER_DRIVE_PIN_O = s_q.drive_pin;
  assign DRIVE_REDUCE_O = s_q.drive_red;
  assign GAIN_MULT_SEL_O = s_q.gain_sel;
  assign WAIT_BUSY_O = s_q.wait_busy;
endmodule : ptpc_top

// ==== verification/ptpc_assertions.sv ====
// port-level concurrent checks for the proximity threshold block
`timescale 1ns/1ps
module ptpc_checker (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] ADDR_I,
  input wire logic CMD_CLR_I,
  input wire logic PROX_DONE_I,
  input wire logic LIGHT_DONE_I,
  input wire logic WAIT_START_I,
  input wire logic [7:0] RDATA_O,
  input wire logic IRQ_N_O,
  input wire logic EMITTER_DRIVE_PIN_O,
  input wire logic DRIVE_REDUCE_O,
  input wire logic [2:0] GAIN_MULT_SEL_O,
  input wire logic WAIT_BUSY_O
);
  logic [11:0] hi_q; // cycles the emitter pin has stood high
  logic [11:0] hi_d; // next high count
  logic cause; // something that may raise a flag or unmask it
  logic undo; // something that may drop the interrupt
  logic cfg_wr; // configuration byte written
  assign cause = PROX_DONE_I | LIGHT_DONE_I | WR_I;
  assign undo = CMD_CLR_I | WR_I;
  assign cfg_wr = WR_I && (ADDR_I == 8'h0d);
  // measure each pulse high time; a low pin clears it
  always_comb hi_d = EMITTER_DRIVE_PIN_O ? hi_q + 12'h001 : 12'h000;
  always_ff @(posedge CLK_I) hi_q <= hi_d;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // reset is checked with reset as the cause, so it cannot be disabled by it
  a_reset_outputs: assert property (disable iff (1'b0) !RST_N_I |=> IRQ_N_O && RDATA_O == 8'h00
    && !EMITTER_DRIVE_PIN_O && !WAIT_BUSY_O) else $error("outputs wrong after reset");
  a_irq_cause: assert property ($fell(IRQ_N_O) |-> $past(cause) || $past(cause, 2))
    else $error("interrupt raised without a result or unmask");
  a_irq_held: assert property ($rose(IRQ_N_O) |-> $past(undo) || $past(undo, 2))
    else $error("interrupt dropped without a clear");
  a_status_layout: assert property (RD_I && ADDR_I == 8'h13 |=> RDATA_O[7:6] == 2'h0
    && RDATA_O[3:0] == 4'h0) else $error("status has stray bits");
  a_config_reserved: assert property (RD_I && ADDR_I == 8'h0d |=> RDATA_O[7:3] == 5'h00)
    else $error("reserved configuration bits read back set");
  a_drive_cause: assert property ($changed(DRIVE_REDUCE_O) |-> $past(cfg_wr)
    || $past(cfg_wr, 2)) else $error("drive reduce moved without a write");
  a_gain_code: assert property (GAIN_MULT_SEL_O inside {3'h0, 3'h1})
    else $error("gain scale select out of range");
  a_pulse_width: assert property ($fell(EMITTER_DRIVE_PIN_O) |-> hi_q == 12'h7d0)
    else $error("emitter pulse high time wrong");
  a_wait_cause: assert property ($rose(WAIT_BUSY_O) |-> $past(WAIT_START_I)
    || $past(WAIT_START_I, 2)) else $error("wait began without a start");
endmodule // ptpc_checker
bind ptpc_top ptpc_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .WR_I(WR_I), .RD_I(RD_I),
  .ADDR_I(ADDR_I), .CMD_CLR_I(CMD_CLR_I), .PROX_DONE_I(PROX_DONE_I), .LIGHT_DONE_I(LIGHT_DONE_I),
  .WAIT_START_I(WAIT_START_I), .RDATA_O(RDATA_O), .IRQ_N_O(IRQ_N_O),
  .EMITTER_DRIVE_PIN_O(EMITTER_DRIVE_PIN_O), .DRIVE_REDUCE_O(DRIVE_REDUCE_O),
  .GAIN_MULT_SEL_O(GAIN_MULT_SEL_O), .WAIT_BUSY_O(WAIT_BUSY_O));

// ==== verification/ptpc_led_load.sv ====
// emitter load model: counts flashes seen on the emitter pin
`timescale 1ns/1ps
module ptpc_led_load (
  input wire logic clk_i,
  input wire logic pin_i, // emitter drive level
  output logic [15:0] pulses_o // rising edges seen so far
);
  logic last_q; // pin level at the previous edge
  initial pulses_o = 16'h0000;
  // one flash per rising edge; the bench compares differences only
  always @(posedge clk_i)
  begin
    last_q <= pin_i;
    if (pin_i && !last_q) pulses_o <= pulses_o + 16'h0001;
  end
endmodule // ptpc_led_load

// ==== verification/test_proximity_threshold_persistence_config.sv ====
// self-checking bench for the proximity threshold and persistence block
`timescale 1ns/1ps
module test_proximity_threshold_persistence_config;
  logic clk, rst_n, wr, rd, clr, pdone, ldone, wstart, astart, ce; // driven strobes
  logic [7:0] addr, wdata, rdata; // register bus
  logic [4:0] code; // clear command code
  logic [15:0] pres, ch0, pulses, base; // results and flash counts
  logic irq_n, emit, drv, wbusy, rd_seen; // observed outputs
  logic [2:0] gsel; // gain scale select
  logic [7:0] exp_q[$]; // expected read data, oldest first
  int failures, compares, cycles;
  integer seed = 32'he2d3f49f;
  ptpc_top dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .WR_I(wr), .RD_I(rd), .ADDR_I(addr),
    .WDATA_I(wdata), .CMD_CLR_I(clr), .CMD_CODE_I(code), .PROX_DONE_I(pdone),
    .PROX_RESULT_I(pres), .LIGHT_DONE_I(ldone), .CH0_RESULT_I(ch0), .WAIT_START_I(wstart),
    .ACCUM_START_I(astart), .RDATA_O(rdata), .IRQ_N_O(irq_n), .EMITTER_DRIVE_PIN_O(emit),
    .DRIVE_REDUCE_O(drv), .GAIN_MULT_SEL_O(gsel), .WAIT_BUSY_O(wbusy));
  ptpc_led_load u_load (.clk_i(clk), .pin_i(emit), .pulses_o(pulses));
  // clock at 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic close_out();
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h wanted %h", $time, what, got, exp);
    end
  endtask
  // hang guard, well above the expected run of about 19000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      $display("unexpected at %0t: run too long", $time);
      close_out();
    end
  end
  // read answers on the taking edge itself, flagged here by rd_seen
  always @(posedge clk) rd_seen <= rd && rst_n;
  // read data is settled by the falling edge
  always @(negedge clk)
    if (rd_seen && exp_q.size() > 0) check(rdata, exp_q.pop_front(), "read data");
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic clr_cmd(input logic [4:0] c);
    @(negedge clk);
    {clr, code} = {1'b1, c};
    @(negedge clk);
    clr = 1'b0;
  endtask
  task automatic kick(input logic w, input logic a);
    @(negedge clk);
    {wstart, astart} = {w, a};
    @(negedge clk);
    {wstart, astart} = 2'b00;
  endtask
  task automatic meas(input logic light, input logic [15:0] v);
    @(negedge clk);
    {pdone, ldone, pres, ch0} = {!light, light, v, v};
    @(negedge clk);
    {pdone, ldone} = 2'b00;
  endtask
  // random result strictly below 0x0100 or above 0x0200
  function automatic logic [15:0] outv();
    logic [31:0] r;
    r = $random(seed);
    return r[0] ? {8'h00, r[15:8]} : {8'h03, r[15:8]};
  endfunction
  // a run one short, broken by an in-range edge value, then a full run
  task automatic persist(input logic light, input logic [3:0] c, input int need);
    wr_reg(8'h0c, light ? {4'h0, c} : {c, 4'h0});
    if (c != 4'h0)
    begin
      repeat (need - 1) meas(light, outv());
      meas(light, light ? 16'h0200 : 16'h0100);
      repeat (need - 1) meas(light, outv());
      tick(2);
      check(irq_n, 1'b1, "early interrupt");
    end
    meas(light, c == 4'h0 ? 16'h0180 : outv());
    tick(2);
    check(irq_n, 1'b0, "interrupt");
    rd_reg(8'h13, light ? 8'h10 : 8'h20);
    clr_cmd(light ? 5'h06 : 5'h05);
    tick(2);
    check(irq_n, 1'b1, "interrupt clear");
  endtask
  // main sequence
  initial
  begin
    {rst_n, wr, rd, clr, pdone, ldone, wstart, astart} = 8'h00;
    {addr, wdata, code, pres, ch0} = '0;
    ce = 1'b1; // running unless a test freezes it
    tick(4);
    rst_n = 1'b1;
    for (int a = 8; a <= 14; a++) rd_reg(a[7:0], 8'h00);
    rd_reg(8'h03, 8'hff);
    rd_reg(8'h13, 8'h00);
    rd_reg(8'h20, 8'h00);
    $display("test reset values done");
    for (int a = 8; a <= 11; a++)
    begin
      wdata = $random(seed);
      wr_reg(a[7:0], wdata);
      rd_reg(a[7:0], wdata);
    end
    for (int b = 4; b <= 8; b += 4)
    begin
      wr_reg(b[7:0], 8'h00);
      wr_reg(b[7:0] + 8'h01, 8'h01);
      wr_reg(b[7:0] + 8'h02, 8'h00);
      wr_reg(b[7:0] + 8'h03, 8'h02);
    end
    wr_reg(8'h0d, 8'h07);
    rd_reg(8'h0d, 8'h07);
    tick(2);
    check(drv, 1'b1, "drive reduce");
    check(gsel, 3'h1, "gain scale");
    wr_reg(8'h0d, 8'h02);
    tick(2);
    check(drv, 1'b0, "drive reduce off");
    check(gsel, 3'h0, "gain unscaled");
    ce = 1'b0; // frozen: this write must not land
    wr_reg(8'h0e, 8'h55);
    ce = 1'b1;
    rd_reg(8'h0e, 8'h00);
    $display("test registers done");
    wr_reg(8'h00, 8'h08);
    kick(1'b1, 1'b0);
    tick(1);
    check(wbusy, 1'b1, "wait busy");
    wr_reg(8'h0c, 8'h10);
    meas(1'b0, outv());
    tick(2);
    check(irq_n, 1'b1, "masked interrupt");
    clr_cmd(5'h07);
    wr_reg(8'h00, 8'h38);
    for (int c = 0; c < 16; c++) persist(1'b0, c[3:0], c);
    for (int c = 0; c < 16; c++) persist(1'b1, c[3:0], c <= 3 ? c : 5 * (c - 3));
    $display("test persistence done");
    wr_reg(8'h0e, 8'h03);
    rd_reg(8'h0e, 8'h03);
    base = pulses;
    kick(1'b0, 1'b1);
    tick(100);
    kick(1'b0, 1'b1);
    tick(7800);
    check(pulses - base, 16'h0002, "pulse period");
    tick(4400);
    check(pulses - base, 16'h0003, "pulse count");
    wr_reg(8'h0e, 8'h00);
    base = pulses;
    kick(1'b0, 1'b1);
    tick(4200);
    check(pulses - base, 16'h0000, "zero pulses");
    $display("test emitter done");
    close_out();
  end
endmodule // test_proximity_threshold_persistence_config
